//--- pmr_bank.sv
/*
  Per-port management register bank reached over the serial
  management pins (clock and two-way data). Holds control, quick
  status, event enables and flags, lamp setup, side-band signalling
  and two transmit shaping registers.
  Assumes all inputs are synchronous to i_mclk, the management clock
  is no faster than a quarter of i_mclk, and link status comes as levels.
*/
// How it works
// R1: Writing one to control bit 15 resets the port; bit self-clears.
// R2: Control bit 14 enables loopback; default cleared.
// R3: Bits 6 and 13 pick speed: 00 is 10M, 01 is 100M; others forbidden.
// R4: Control bit 12 enables auto-negotiation.
// R5: Control bit 11 powers the port down; default cleared.
// R6: Writing one to control bit 9 restarts auto-negotiation; self-clears.
// R7: Control bit 8 selects full duplex when set, half when cleared.
// R8: Control bit 7 is writable but drives nothing.
// R9: Management writes zeros to bits 10 and 5:0, ignores them on read.
// R10: Register 17 reports speed, activity, collision, link, duplex, negotiation, errors.
// R11: Register 18 masks events and enables output; register 19 reports events.
// R12: Register 25 holds two signalling fields and a program enable in bit 0.
// R13: Control bits 12, 13 and 8 take their reset values from pins.
// R14: Management never enables auto-negotiation in fiber operation.
// R15: Interrupt asserts only when enabled and either an unmasked event is pending or the test bit is set.
// R16: Lamp setup selects three lamp sources, blink rate, stretch and inversion.
module pmr_bank
  import pmr_pkg::*;
(
  input wire logic i_mclk, // 40 MHz clock
  input wire logic i_arst_n, // Async reset, active low
  input wire logic [4:0] i_phy_addr, // Port address on the management bus
  input wire logic i_mdc, // Management clock, sampled
  input wire logic i_mdio, // Management data in
  output logic o_mdio, // Management data out
  output logic o_mdio_oe, // Management data drive enable
  input wire logic i_cfg_an_enable, // Pin default for negotiation enable
  input wire logic i_cfg_speed_100, // Pin default for speed
  input wire logic i_cfg_full_duplex, // Pin default for duplex
  input wire logic i_speed_100, // Current speed is 100M
  input wire logic i_tx_active, // Transmit activity
  input wire logic i_rx_active, // Receive activity
  input wire logic i_collision, // Collision seen
  input wire logic i_link_up, // Link up
  input wire logic i_full_duplex, // Current duplex is full
  input wire logic i_an_complete, // Negotiation complete
  input wire logic i_polarity_rev, // Receive polarity reversed
  input wire logic i_pause, // Pause agreed
  input wire logic i_error, // Receive error seen
  output logic o_port_reset, // Soft reset pulse
  output logic o_an_restart, // Negotiation restart pulse
  output logic o_loopback, // Loopback mode
  output logic o_speed_100, // Selected speed 100M
  output logic o_an_enable, // Negotiation enabled
  output logic o_power_down, // Power-down
  output logic o_full_duplex, // Selected full duplex
  output logic o_mgmt_irq, // Interrupt, active high
  output logic [15:0] o_lamp_setup, // Lamp setup register
  output logic [15:0] o_side_band, // Side-band signalling register
  output logic [15:0] o_tx_shaping_one, // Transmit shaping one
  output logic [15:0] o_tx_shaping_two // Transmit shaping two
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wr,
                                        input logic [15:0] mask);
    merge = (old & ~mask) | (wr & mask);
  endfunction
  function automatic logic irq_cond(input logic [3:0] ev, input logic [15:0] en);
    irq_cond = en[IE_OUT_ENABLE] & ((|(ev & en[EV_AN_DONE:EV_LINK])) | en[IE_TEST]);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pmr_state_t state, next_state;
  logic mdc_q, next_mdc_q;
  logic [5:0] cnt, next_cnt;
  logic [15:0] shreg, next_shreg;
  logic [15:0] rdata, next_rdata;
  logic is_read, next_is_read;
  logic is_write, next_is_write;
  logic [4:0] reg_addr, next_reg_addr;
  logic mdio_out, next_mdio_out;
  logic mdio_oe, next_mdio_oe;
  logic [15:0] ctrl, next_ctrl;
  logic [15:0] ien, next_ien;
  logic [3:0] evt, next_evt;
  logic [15:0] lamp, next_lamp;
  logic [15:0] side, next_side;
  logic [15:0] tx1, next_tx1;
  logic [15:0] tx2, next_tx2;
  logic strap_done, next_strap_done;
  logic soft_rst, next_soft_rst;
  logic restart, next_restart;
  logic irq, next_irq;
  logic [3:0] prev, next_prev;
  logic speed_q, next_speed_q;
  logic mdc_rise;
  logic wr_en;
  logic rd_take;
  logic [15:0] wr_data;
  logic [3:0] ev_now;
  logic [3:0] ev_set;
  logic mgmt_flag;
  logic [15:0] quick;
  logic [15:0] flags_word;

  // ----------------------------------------------------------------
  // Status words
  // ----------------------------------------------------------------
  always_comb begin
    quick = {1'b0, i_speed_100, i_tx_active, i_rx_active, i_collision, i_link_up, // see R10
             i_full_duplex, ctrl[CTL_AN_ENABLE], i_an_complete, 1'b0, i_polarity_rev, i_pause,
             i_error, 3'b000};
    ev_now = {i_an_complete, i_speed_100, i_full_duplex, i_link_up};
    ev_set = {ev_now[3] & ~prev[3], ev_now[2:0] ^ prev[2:0]} & {4{strap_done}}; // see R11
    mgmt_flag = irq_cond(evt, ien); // see R15
    flags_word = 16'h0000;
    flags_word[EV_AN_DONE:EV_LINK] = evt;
    flags_word[EV_MGMT_FLAG] = mgmt_flag;
  end

  // ----------------------------------------------------------------
  // Serial frame engine
  // ----------------------------------------------------------------
  always_comb begin
    mdc_rise = i_mdc & ~mdc_q;
    next_mdc_q = i_mdc;
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_rdata = rdata;
    next_is_read = is_read;
    next_is_write = is_write;
    next_reg_addr = reg_addr;
    next_mdio_out = mdio_out;
    next_mdio_oe = mdio_oe;
    wr_en = 1'b0;
    rd_take = 1'b0;
    wr_data = {shreg[14:0], i_mdio};
    if (mdc_rise) begin
      case (state)
        PMR_PRE: begin
          if (i_mdio && cnt != PREAMBLE_ONES) begin
            next_cnt = cnt + 6'h01;
          end else if (!i_mdio && cnt == PREAMBLE_ONES) begin
            next_state = PMR_HDR;
            next_cnt = 6'h01;
            next_shreg = 16'h0000;
          end else if (!i_mdio) begin
            next_cnt = 6'h00;
          end
        end
        PMR_HDR: begin
          next_shreg = {shreg[14:0], i_mdio};
          next_cnt = cnt + 6'h01;
          if (cnt == HEADER_BITS) begin
            next_state = PMR_TA;
            next_cnt = 6'h00;
            next_reg_addr = {shreg[3:0], i_mdio};
            next_is_read = shreg[11] && (shreg[10:9] == OP_READ) && (shreg[8:4] == i_phy_addr);
            next_is_write = shreg[11] && (shreg[10:9] == OP_WRITE) && (shreg[8:4] == i_phy_addr);
          end
        end
        PMR_TA: begin
          next_cnt = cnt + 6'h01;
          if (cnt == 6'h00) begin
            next_mdio_oe = is_read;
            next_mdio_out = 1'b0;
            rd_take = is_read;
          end else begin
            next_state = PMR_DATA;
            next_cnt = 6'h00;
            next_mdio_out = rdata[15];
            next_rdata = {rdata[14:0], 1'b0};
          end
        end
        PMR_DATA: begin
          next_shreg = wr_data;
          next_cnt = cnt + 6'h01;
          next_mdio_out = rdata[15];
          next_rdata = {rdata[14:0], 1'b0};
          if (cnt == DATA_BITS - 6'h01) begin
            wr_en = is_write;
            next_state = PMR_PRE;
            next_cnt = 6'h00;
            next_mdio_oe = 1'b0;
            next_is_read = 1'b0;
            next_is_write = 1'b0;
          end
        end
        default: begin
          next_state = PMR_PRE;
          next_cnt = 6'h00;
        end
      endcase
    end
    if (rd_take) begin
      case (reg_addr)
        ADDR_PORT_CONTROL: next_rdata = ctrl; // see R1, R6
        ADDR_QUICK_PORT_STATUS: next_rdata = quick;
        ADDR_EVENT_MASK_ENABLE: next_rdata = ien;
        ADDR_EVENT_FLAGS: next_rdata = flags_word;
        ADDR_LAMP_SETUP: next_rdata = lamp;
        ADDR_SIDE_BAND_SIGNALLING: next_rdata = side;
        ADDR_TX_SHAPING_ONE: next_rdata = tx1;
        ADDR_TX_SHAPING_TWO: next_rdata = tx2;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    next_ien = ien;
    next_lamp = lamp;
    next_side = side;
    next_tx1 = tx1;
    next_tx2 = tx2;
    next_strap_done = 1'b1;
    next_soft_rst = 1'b0;
    next_restart = 1'b0;
    next_prev = ev_now;
    // Read clear loses to a new event
    next_evt = ((rd_take && reg_addr == ADDR_EVENT_FLAGS) ? 4'h0 : evt) | ev_set; // see R11
    if (!strap_done) begin
      next_ctrl[CTL_SPEED_LSB] = i_cfg_speed_100; // see R13
      next_ctrl[CTL_AN_ENABLE] = i_cfg_an_enable; // see R13
      next_ctrl[CTL_FULL_DUPLEX] = i_cfg_full_duplex; // see R13
    end
    if (wr_en) begin
      case (reg_addr)
        ADDR_PORT_CONTROL: begin
          next_ctrl = merge(ctrl, wr_data, MASK_CONTROL); // see R2, R3, R4, R5, R7, R8, R9
          next_soft_rst = wr_data[CTL_RESET]; // see R1
          next_restart = wr_data[CTL_AN_RESTART]; // see R6
        end
        ADDR_EVENT_MASK_ENABLE: next_ien = merge(ien, wr_data, MASK_EVENT_ENABLE); // see R11
        ADDR_LAMP_SETUP: next_lamp = merge(lamp, wr_data, MASK_LAMP); // see R16
        ADDR_SIDE_BAND_SIGNALLING: next_side = merge(side, wr_data, MASK_SIDE_BAND); // see R12
        ADDR_TX_SHAPING_ONE: next_tx1 = merge(tx1, wr_data, MASK_TX_ONE);
        ADDR_TX_SHAPING_TWO: next_tx2 = merge(tx2, wr_data, MASK_TX_TWO);
        default: next_ctrl = ctrl;
      endcase
    end
    if (soft_rst) begin
      // Soft reset restores defaults and re-reads the pins
      next_ctrl = RST_CONTROL; // see R1
      next_ien = RST_EVENT_ENABLE;
      next_lamp = RST_LAMP;
      next_side = RST_SIDE_BAND;
      next_tx1 = RST_TX_ONE;
      next_tx2 = RST_TX_TWO;
      next_evt = 4'h0;
      next_strap_done = 1'b0;
    end
    next_speed_q = next_ctrl[CTL_SPEED_LSB] & ~next_ctrl[CTL_SPEED_MSB]; // see R3
    next_irq = irq_cond(next_evt, next_ien); // see R15
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= PMR_PRE;
      mdc_q <= 1'b0;
      cnt <= 6'h00;
      shreg <= 16'h0000;
      rdata <= 16'h0000;
      is_read <= 1'b0;
      is_write <= 1'b0;
      reg_addr <= 5'h00;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
      ctrl <= RST_CONTROL;
      ien <= RST_EVENT_ENABLE;
      evt <= 4'h0;
      lamp <= RST_LAMP;
      side <= RST_SIDE_BAND;
      tx1 <= RST_TX_ONE;
      tx2 <= RST_TX_TWO;
      strap_done <= 1'b0;
      soft_rst <= 1'b0;
      restart <= 1'b0;
      irq <= 1'b0;
      prev <= 4'h0;
      speed_q <= 1'b0;
    end else begin
      state <= next_state;
      mdc_q <= next_mdc_q;
      cnt <= next_cnt;
      shreg <= next_shreg;
      rdata <= next_rdata;
      is_read <= next_is_read;
      is_write <= next_is_write;
      reg_addr <= next_reg_addr;
      mdio_out <= next_mdio_out;
      mdio_oe <= next_mdio_oe;
      ctrl <= next_ctrl;
      ien <= next_ien;
      evt <= next_evt;
      lamp <= next_lamp;
      side <= next_side;
      tx1 <= next_tx1;
      tx2 <= next_tx2;
      strap_done <= next_strap_done;
      soft_rst <= next_soft_rst;
      restart <= next_restart;
      irq <= next_irq;
      prev <= next_prev;
      speed_q <= next_speed_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_mdio = mdio_out;
  assign o_mdio_oe = mdio_oe;
  assign o_port_reset = soft_rst;
  assign o_an_restart = restart;
  assign o_loopback = ctrl[CTL_LOOPBACK];
  assign o_speed_100 = speed_q;
  assign o_an_enable = ctrl[CTL_AN_ENABLE];
  assign o_power_down = ctrl[CTL_POWER_DOWN];
  assign o_full_duplex = ctrl[CTL_FULL_DUPLEX];
  assign o_mgmt_irq = irq;
  assign o_lamp_setup = lamp;
  assign o_side_band = side;
  assign o_tx_shaping_one = tx1;
  assign o_tx_shaping_two = tx2;
endmodule

//--- pmr_bank_monitor.sv
/*
  Port checks for the port management register bank.
  Assumes a bind to pmr_bank; every output is registered on i_mclk.
*/
module pmr_bank_monitor (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_mdc,
  input wire logic i_cfg_an_enable,
  input wire logic i_cfg_speed_100,
  input wire logic i_cfg_full_duplex,
  input wire logic o_mdio,
  input wire logic o_mdio_oe,
  input wire logic o_port_reset,
  input wire logic o_an_restart,
  input wire logic o_loopback,
  input wire logic o_speed_100,
  input wire logic o_an_enable,
  input wire logic o_power_down,
  input wire logic o_full_duplex,
  input wire logic [15:0] o_lamp_setup,
  input wire logic [15:0] o_side_band
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mdc_q;
  logic rise;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mdc_q <= 1'b0;
    end else begin
      mdc_q <= i_mdc;
    end
  end
  assign rise = i_mdc & ~mdc_q;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // ----------------------------------------------------------------
  // Soft reset, pulse, pin default, setting and serial line checks
  // ----------------------------------------------------------------
  sequence s_cleared;
    !o_port_reset && !o_loopback && !o_power_down && o_lamp_setup == 16'h0000 &&
      o_side_band == 16'h0000;
  endsequence
  sequence s_pins_loaded;
    o_an_enable == i_cfg_an_enable && o_full_duplex == i_cfg_full_duplex &&
      o_speed_100 == i_cfg_speed_100;
  endsequence
  a_reset_pulse_short: assert property (o_port_reset |=> !o_port_reset)
    else $error("port reset pulse too long");
  a_reset_clears_all: assert property (o_port_reset |=> s_cleared ##1 s_pins_loaded)
    else $error("soft reset did not clear and reload");
  a_restart_pulse_short: assert property (o_an_restart |=> !o_an_restart)
    else $error("restart pulse too long");
  a_pulse_after_frame: assert property ($rose(o_port_reset) || $rose(o_an_restart) |->
    $past(rise) || $past(rise, 2)) else $error("pulse without a frame");
  a_pin_defaults_load: assert property ($rose(i_arst_n) |=> s_pins_loaded)
    else $error("pin defaults not loaded");
  a_setup_by_write: assert property ($changed({o_loopback, o_power_down, o_lamp_setup,
    o_side_band}) |-> $past(rise) || $past(rise, 2) || $past(o_port_reset))
    else $error("setting changed without a write");
  a_turn_drives_zero: assert property ($rose(o_mdio_oe) |->
    !o_mdio && ($past(rise) || $past(rise, 2))) else $error("bad turnaround");
  a_read_bit_hold: assert property (o_mdio_oe && $past(o_mdio_oe) && $changed(o_mdio) |->
    $past(rise) || $past(rise, 2)) else $error("read bit changed early");
endmodule

//--- pmr_bank_tb_top.sv
/*
  Bench for the port management register bank: random settings and
  status, hand-picked refusals, soft reset and event cases.
  Assumes the shared data line is pulled up when nobody drives it.
*/
module pmr_bank_tb_top
  import pmr_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] phy = 5'h03;
  logic [2:0] cfg = 3'h5;
  logic [9:0] st = 10'h000;
  logic mdc, m_d, m_oe, d_d, d_oe, mdio_w, rst_p, anr_p, irq, lb, spd, ane, pd, fd;
  logic [15:0] lamp, sb, tx1, tx2, rdv, d, keep, ctl;
  logic [4:0] ra [6] = '{ADDR_PORT_CONTROL, ADDR_EVENT_MASK_ENABLE, ADDR_LAMP_SETUP,
                         ADDR_SIDE_BAND_SIGNALLING, ADDR_TX_SHAPING_ONE, ADDR_TX_SHAPING_TWO};
  logic [15:0] rm [6] = '{MASK_CONTROL, MASK_EVENT_ENABLE, MASK_LAMP, MASK_SIDE_BAND,
                          MASK_TX_ONE, MASK_TX_TWO};
  logic [15:0] rr [6] = '{RST_CONTROL, RST_EVENT_ENABLE, RST_LAMP, RST_SIDE_BAND,
                          RST_TX_ONE, RST_TX_TWO};
  int ev [4] = '{5, 4, 9, 3};
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int n_prst = 0;
  int n_anr = 0;
  int p0;
  always #12.5 clk = ~clk;
  assign mdio_w = d_oe ? d_d : (m_oe ? m_d : 1'b1);
  pmr_bank u_dut (.i_mclk(clk), .i_arst_n(rst_n), .i_phy_addr(phy), .i_mdc(mdc),
    .i_mdio(mdio_w), .o_mdio(d_d), .o_mdio_oe(d_oe), .i_cfg_an_enable(cfg[2]),
    .i_cfg_speed_100(cfg[1]), .i_cfg_full_duplex(cfg[0]), .i_speed_100(st[9]),
    .i_tx_active(st[8]), .i_rx_active(st[7]), .i_collision(st[6]), .i_link_up(st[5]),
    .i_full_duplex(st[4]), .i_an_complete(st[3]), .i_polarity_rev(st[2]),
    .i_pause(st[1]), .i_error(st[0]), .o_port_reset(rst_p), .o_an_restart(anr_p),
    .o_loopback(lb), .o_speed_100(spd), .o_an_enable(ane), .o_power_down(pd),
    .o_full_duplex(fd), .o_mgmt_irq(irq), .o_lamp_setup(lamp), .o_side_band(sb),
    .o_tx_shaping_one(tx1), .o_tx_shaping_two(tx2));
  pmr_mdio_master u_mgr (.i_mclk(clk), .i_mdio(mdio_w), .o_mdc(mdc), .o_mdio(m_d),
    .o_mdio_oe(m_oe));
  task automatic give_verdict();
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    n_prst += int'(rst_p === 1'b1);
    n_anr += int'(anr_p === 1'b1);
    if (cyc == 80000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xf(input int pre, input logic [1:0] op, input logic [4:0] a,
                    input logic [4:0] rg, input logic [15:0] wd);
    u_mgr.half = 2 + $urandom_range(2);
    u_mgr.xfer(pre, op, a, rg, wd, rdv);
    repeat (3) @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] rg, input logic [15:0] wd);
    xf(32, OP_WRITE, phy, rg, wd);
  endtask
  task automatic rd(input logic [4:0] rg);
    xf(32, OP_READ, phy, rg, 16'h0000);
  endtask
  function automatic logic [15:0] pin_ctrl(input logic [2:0] c);
    return {2'b00, c[1], c[2], 3'b000, c[0], 8'h00};
  endfunction
  function automatic logic [15:0] quick(input logic [9:0] s, input logic an);
    return {1'b0, s[9:4], an, s[3], 1'b0, s[2:0], 3'b000};
  endfunction
  function automatic logic [15:0] outv(input int k);
    case (k)
      2: return lamp;
      3: return sb;
      4: return tx1;
      5: return tx2;
      default: return {1'b0, lb, spd, ane, pd, 2'b00, fd, 8'h00};
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    d = 16'($urandom(32'hfbc40493));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 6; k++) begin
      rd(ra[k]);
      chk("reset value", k == 0 ? pin_ctrl(cfg) : rr[k], rdv);
    end
    repeat (3) for (int k = 0; k < 6; k++) begin
      d = 16'($urandom);
      if (k == 0) d &= 16'h7980;
      wr(ra[k], d);
      rd(ra[k]);
      chk("readback", d & rm[k], rdv);
      if (k != 1) chk("port value", k == 0 ? d & 16'h7900 : d & rm[k], outv(k));
      if (k == 0) ctl = d;
    end
    keep = lamp;
    xf(32, OP_WRITE, phy ^ 5'h01, ADDR_LAMP_SETUP, ~keep);
    xf(20, OP_WRITE, phy, ADDR_LAMP_SETUP, ~keep);
    chk("refused write", keep, lamp);
    xf(32, OP_READ, phy ^ 5'h01, ADDR_LAMP_SETUP, 16'h0000);
    chk("foreign read", 16'hffff, rdv);
    wr(5'h05, 16'hffff);
    rd(5'h05);
    chk("unmapped read", 16'h0000, rdv);
    st <= 10'($urandom);
    repeat (4) @(posedge clk);
    rd(ADDR_QUICK_PORT_STATUS);
    chk("quick status", quick(st, ctl[12]), rdv);
    p0 = n_prst;
    wr(ADDR_PORT_CONTROL, 16'hc000);
    chk("reset pulses", 16'(p0 + 1), 16'(n_prst));
    chk("lamp after soft reset", 16'h0000, lamp);
    rd(ADDR_PORT_CONTROL);
    chk("control after soft reset", pin_ctrl(cfg), rdv);
    p0 = n_anr;
    wr(ADDR_PORT_CONTROL, 16'h1200);
    chk("restart pulses", 16'(p0 + 1), 16'(n_anr));
    rd(ADDR_PORT_CONTROL);
    chk("restart self clears", 16'h1000, rdv);
    st <= st & ~10'h008;
    repeat (4) @(posedge clk);
    rd(ADDR_EVENT_FLAGS);
    wr(ADDR_EVENT_MASK_ENABLE, 16'h00f2);
    chk("irq idle", 16'h0000, irq);
    for (int k = 0; k < 4; k++) begin
      st[ev[k]] <= ~st[ev[k]];
      repeat (4) @(posedge clk);
      chk("irq raised", 16'h0001, irq);
      rd(ADDR_EVENT_FLAGS);
      chk("event flags", (16'h0010 << k) | 16'h0004, rdv);
      chk("irq after read", 16'h0000, irq);
    end
    wr(ADDR_EVENT_MASK_ENABLE, 16'h0002);
    st[5] <= ~st[5];
    repeat (4) @(posedge clk);
    chk("masked event", 16'h0000, irq);
    wr(ADDR_EVENT_MASK_ENABLE, 16'h00f0);
    st[4] <= ~st[4];
    repeat (4) @(posedge clk);
    chk("output disabled", 16'h0000, irq);
    wr(ADDR_EVENT_MASK_ENABLE, 16'h0003);
    chk("test interrupt", 16'h0001, irq);
    wr(ADDR_EVENT_MASK_ENABLE, 16'h00f2);
    chk("pending unmasked", 16'h0001, irq);
    rd(ADDR_EVENT_FLAGS);
    chk("pending flags", 16'h0034, rdv);
    rst_n <= 1'b0;
    cfg <= ~cfg;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pins after reset", pin_ctrl(cfg), {2'b00, spd, ane, 3'b000, fd, 8'h00});
    give_verdict();
  end
endmodule
bind pmr_bank pmr_bank_monitor u_mon (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_mdc(i_mdc),
  .i_cfg_an_enable(i_cfg_an_enable), .i_cfg_speed_100(i_cfg_speed_100),
  .i_cfg_full_duplex(i_cfg_full_duplex), .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe),
  .o_port_reset(o_port_reset), .o_an_restart(o_an_restart), .o_loopback(o_loopback),
  .o_speed_100(o_speed_100), .o_an_enable(o_an_enable), .o_power_down(o_power_down),
  .o_full_duplex(o_full_duplex), .o_lamp_setup(o_lamp_setup), .o_side_band(o_side_band));

//--- pmr_mdio_master.sv
/*
  Station management model that sends serial frames to the bank.
  Assumes the bench resolves the data line with a pull-up; the
  management clock stands low between frames.
*/
module pmr_mdio_master
  import pmr_pkg::*;
(
  input wire logic i_mclk, // System clock
  input wire logic i_mdio, // Resolved data line
  output logic o_mdc, // Management clock
  output logic o_mdio, // Data driven
  output logic o_mdio_oe // Drive enable
);
  timeunit 1ns;
  timeprecision 1ps;
  int half = 2;
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_mdio_oe = 1'b0;
  end
  task automatic bit_cyc(input logic b, input logic drv, output logic s);
    @(posedge i_mclk);
    o_mdc <= 1'b0;
    o_mdio <= b;
    o_mdio_oe <= drv;
    repeat (half) @(posedge i_mclk);
    s = i_mdio;
    o_mdc <= 1'b1;
    repeat (half - 1) @(posedge i_mclk);
  endtask
  task automatic xfer(input int pre, input logic [1:0] op, input logic [4:0] phy,
                      input logic [4:0] rg, input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] fr;
    logic s;
    fr = {2'b01, op, phy, rg, 2'b10, wd};
    for (int i = 0; i < pre; i++) bit_cyc(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      bit_cyc(fr[i], op != OP_READ || i > 17, s);
      if (i < 16) rd[i] = s;
    end
    // One released cycle lets the bank drop its drive
    bit_cyc(1'b1, 1'b0, s);
    @(posedge i_mclk);
    o_mdc <= 1'b0;
  endtask
endmodule

//--- pmr_pkg.sv
/*
  Constants for the port management register bank: register indices,
  field positions, write masks, reset values and serial frame codes.
  Assumes a single 40 MHz clock and 16-bit registers.
*/
package pmr_pkg;
  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_PORT_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_QUICK_PORT_STATUS = 5'h11;
  localparam logic [4:0] ADDR_EVENT_MASK_ENABLE = 5'h12;
  localparam logic [4:0] ADDR_EVENT_FLAGS = 5'h13;
  localparam logic [4:0] ADDR_LAMP_SETUP = 5'h14;
  localparam logic [4:0] ADDR_SIDE_BAND_SIGNALLING = 5'h19;
  localparam logic [4:0] ADDR_TX_SHAPING_ONE = 5'h1c;
  localparam logic [4:0] ADDR_TX_SHAPING_TWO = 5'h1e;
  // ----------------------------------------------------------------
  // Control bit positions
  // ----------------------------------------------------------------
  localparam int CTL_RESET = 15;
  localparam int CTL_LOOPBACK = 14;
  localparam int CTL_SPEED_LSB = 13;
  localparam int CTL_AN_ENABLE = 12;
  localparam int CTL_POWER_DOWN = 11;
  localparam int CTL_AN_RESTART = 9;
  localparam int CTL_FULL_DUPLEX = 8;
  localparam int CTL_SPEED_MSB = 6;
  // ----------------------------------------------------------------
  // Event and enable bit positions
  // ----------------------------------------------------------------
  localparam int EV_AN_DONE = 7;
  localparam int EV_SPEED = 6;
  localparam int EV_DUPLEX = 5;
  localparam int EV_LINK = 4;
  localparam int EV_MGMT_FLAG = 2;
  localparam int IE_OUT_ENABLE = 1;
  localparam int IE_TEST = 0;
  // ----------------------------------------------------------------
  // Write masks and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MASK_CONTROL = 16'h7dff;
  localparam logic [15:0] MASK_EVENT_ENABLE = 16'h00f3;
  localparam logic [15:0] MASK_LAMP = 16'hffff;
  localparam logic [15:0] MASK_SIDE_BAND = 16'h007f;
  localparam logic [15:0] MASK_TX_ONE = 16'h700f;
  localparam logic [15:0] MASK_TX_TWO = 16'h3000;
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [15:0] RST_EVENT_ENABLE = 16'h0000;
  localparam logic [15:0] RST_LAMP = 16'h0000;
  localparam logic [15:0] RST_SIDE_BAND = 16'h0000;
  localparam logic [15:0] RST_TX_ONE = 16'h0000;
  localparam logic [15:0] RST_TX_TWO = 16'h0000;
  // ----------------------------------------------------------------
  // Serial management frame
  // ----------------------------------------------------------------
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [5:0] HEADER_BITS = 6'h0d;
  localparam logic [5:0] DATA_BITS = 6'h10;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  typedef enum logic [1:0] {PMR_PRE, PMR_HDR, PMR_TA, PMR_DATA} pmr_state_t;
endpackage
